// ==== testbench/chi_link_chk.sv ====
// Checker on the pins between sensor end and host end
`timescale 1ns/100ps
`default_nettype none
module chi_link_chk #(
	parameter logic [39:0] CAL_HOLD_CYCLES = chi_pkg::CAL_HOLD_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic uart_txd,
	input wire logic scl,
	input wire logic dev_sda_oe_n,
	input wire logic alarm_o,
	input wire logic alarm_oe_n,
	input wire logic alarm_line,
	input wire logic cal_ref400_pin,
	input wire logic cal_zero_pin,
	input wire logic rst_n_pin
);
	// ----------------
	// Run counters
	// ----------------
	logic [31:0] low_run;
	logic [39:0] cal_run;
	always_ff @(posedge clk) begin
		low_run <= (sys_rst || uart_txd) ? 32'h0 : low_run + 32'h1;
		cal_run <= (sys_rst || (cal_ref400_pin && cal_zero_pin)) ? 40'h0 : cal_run + 40'h1;
	end
	sequence ack_held;
		!dev_sda_oe_n [*8];
	endsequence
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// A sensor reset cuts a frame mid-bit, so it masks the bit-length check
	bit_time_a: assert property (disable iff (sys_rst || !rst_n_pin)
		$rose(uart_txd) |-> low_run != 0 && low_run % 32'(chi_pkg::DIV_DEF) == 0)
		else $error("uart low run is not whole bits");
	sda_change_a: assert property ($changed(dev_sda_oe_n) |-> !scl && !$past(scl))
		else $error("target moved sda outside scl low");
	no_cond_a: assert property (scl && $past(scl) |-> $stable(dev_sda_oe_n))
		else $error("target made a start or stop");
	ack_hold_a: assert property ($rose(scl) && !dev_sda_oe_n |-> ack_held)
		else $error("target low bit not held");
	alarm_sink_a: assert property (!alarm_oe_n |-> !alarm_o && !alarm_line)
		else $error("alarm driven but not sinking");
	cal_pins_a: assert property (cal_ref400_pin || cal_zero_pin)
		else $error("both calibration pins low");
	cal_time_a: assert property ($rose(cal_ref400_pin && cal_zero_pin) |->
		cal_run == CAL_HOLD_CYCLES)
		else $error("calibration hold length wrong");
	rst_hold_a: assert property (!rst_n_pin |=> uart_txd && dev_sda_oe_n && alarm_oe_n)
		else $error("sensor drives pins in reset");
endmodule
`default_nettype wire

// ==== testbench/co2_sensor_host_interface_tb.sv ====
// Bench joining sensor end and host end
`timescale 1ns/100ps
`default_nettype none
module co2_sensor_host_interface_tb;
	// ----------------
	// Signals and rows
	// ----------------
	logic clk, sys_rst, sensor_rst, read_req, cal_ref400_req, cal_zero_req, got_char = 1'b0;
	logic sample_stb, warm_ok, accurate, alarm, cal_ref400_active, cal_zero_active, cal_fault;
	logic read_cmd_stb, busy, nack, rsp_valid, uart_valid, cal_busy;
	logic uart_frame_end;
	logic [1:0] baud_sel;
	logic [15:0] meas_ppm, conc_ppm, alarm_on, alarm_off;
	logic [7:0] rsp_data, uart_data;
	logic [8:0] first_char;
	localparam logic [39:0] CAL_HOLD = 40'h3E8;
	logic [7:0] rsp_q[$];
	int failures = 0, samples_checked = 0, cycles = 0;
	// Rows: alarm on level, alarm off level, measured value
	logic [47:0] row_in[8] = '{48'h03E8_0320_0384, 48'h03E8_0320_03E8, 48'h03E8_0320_0384,
		48'h03E8_0320_0320, 48'h03E8_0320_09C4, 48'h03E8_0320_01F4, 48'h01F4_0190_0258,
		48'h01F4_0190_01C2};
	logic [16:0] row_exp[8] = '{17'h10384, 17'h103E8, 17'h10384, 17'h00320, 17'h107D0, 17'h001F4,
		17'h10258, 17'h101C2};
	logic [7:0] rsp_exp[7] = '{8'h08, 8'h04, 8'hE7, 8'h00, 8'h00, 8'h00, 8'h00};
	chi_link_if chi_link_if_inst();
	chi_device_end #(.SAMPLE_CYCLES(36'h7D0), .WARM_CYCLES(36'h64), .ACCURATE_CYCLES(36'hC8))
		chi_device_end_inst (.clk(clk), .sys_rst(sys_rst), .link(chi_link_if_inst.dev),
		.meas_ppm(meas_ppm), .baud_sel(baud_sel), .alarm_on_ppm(alarm_on),
		.alarm_off_ppm(alarm_off), .conc_ppm(conc_ppm), .sample_stb(sample_stb),
		.warm_ok(warm_ok), .accurate(accurate), .alarm(alarm), .cal_ref400_active(cal_ref400_active),
		.cal_zero_active(cal_zero_active), .cal_fault(cal_fault), .read_cmd_stb(read_cmd_stb));
	chi_host_end #(.RD_WAIT_CYCLES(36'h32), .CAL_HOLD_CYCLES(CAL_HOLD)) chi_host_end_inst (
		.clk(clk), .sys_rst(sys_rst), .link(chi_link_if_inst.host), .sensor_rst(sensor_rst),
		.read_req(read_req), .baud_sel(baud_sel), .cal_ref400_req(cal_ref400_req),
		.cal_zero_req(cal_zero_req), .busy(busy), .nack(nack), .rsp_data(rsp_data),
		.rsp_valid(rsp_valid), .uart_data(uart_data), .uart_valid(uart_valid),
		.uart_frame_end(uart_frame_end), .cal_busy(cal_busy));
	chi_link_chk #(.CAL_HOLD_CYCLES(CAL_HOLD)) chi_link_chk_inst (.clk(clk), .sys_rst(sys_rst),
		.uart_txd(chi_link_if_inst.uart_txd), .scl(chi_link_if_inst.scl),
		.dev_sda_oe_n(chi_link_if_inst.dev_sda_oe_n), .alarm_o(chi_link_if_inst.alarm_o),
		.alarm_oe_n(chi_link_if_inst.alarm_oe_n), .alarm_line(chi_link_if_inst.alarm_line),
		.cal_ref400_pin(chi_link_if_inst.cal_ref400_pin),
		.cal_zero_pin(chi_link_if_inst.cal_zero_pin), .rst_n_pin(chi_link_if_inst.rst_n_pin));
	task automatic check(input logic [16:0] seen, input logic [16:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Collects bytes in the background; only the first report byte is kept
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (rsp_valid) rsp_q.push_back(rsp_data);
		if (uart_valid && !got_char) first_char <= {uart_frame_end, uart_data};
		if (uart_valid) got_char <= 1'b1;
		if (cycles == 105000) begin
			failures++;
			finish_test();
		end
	end
	initial begin
		sys_rst = 1'b1;
		sensor_rst = 1'b0;
		read_req = 1'b0;
		cal_ref400_req = 1'b0;
		cal_zero_req = 1'b0;
		meas_ppm = 16'h04E7;
		alarm_on = chi_pkg::ALARM_ON_DEF;
		alarm_off = chi_pkg::ALARM_OFF_DEF;
		baud_sel = chi_pkg::BSEL_DEF;
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		read_req <= 1'b1;
		@(posedge clk);
		read_req <= 1'b0;
		// Snapshot must hold 1255 before the value is moved
		@(posedge clk iff read_cmd_stb);
		for (int i = 0; i < 8; i++) begin
			{alarm_on, alarm_off, meas_ppm} <= row_in[i];
			repeat (2) @(posedge clk iff sample_stb);
			@(posedge clk);
			check({alarm, conc_ppm}, row_exp[i]);
			check(17'(chi_link_if_inst.alarm_line), 17'(!row_exp[i][16]));
		end
		check(17'(accurate), 17'h1);
		@(posedge clk iff !busy);
		check(17'(nack), 17'h0);
		check(17'(rsp_q.size()), 17'h7);
		foreach (rsp_exp[i]) check(17'(rsp_q[i]), 17'(rsp_exp[i]));
		check(17'(first_char), 17'h20);
		for (int k = 0; k < 2; k++) begin
			cal_ref400_req <= (k == 0);
			cal_zero_req <= (k == 1);
			@(posedge clk);
			cal_ref400_req <= 1'b0;
			cal_zero_req <= 1'b0;
			repeat (4) @(posedge clk);
			check(17'({cal_ref400_active, cal_zero_active, cal_fault}), 17'(k ? 2 : 4));
			@(posedge clk iff !cal_busy);
			repeat (4) @(posedge clk);
			check(17'({cal_ref400_active, cal_zero_active}), 17'h0);
		end
		sensor_rst <= 1'b1;
		repeat (4) @(posedge clk);
		check({warm_ok, conc_ppm}, 17'h0);
		sensor_rst <= 1'b0;
		@(posedge clk iff warm_ok);
		check(17'(chi_link_if_inst.uart_txd), 17'h1);
		@(posedge clk iff sample_stb);
		check({alarm, conc_ppm}, 17'h001C2);
		finish_test();
	end
endmodule
`default_nettype wire

// ==== verilog/chi_device_end.sv ====
// Sensor end: UART reporter, I2C target, alarm and calibration pins
`timescale 1ns/100ps
`default_nettype none
module chi_device_end #(
	parameter logic [35:0] SAMPLE_CYCLES = chi_pkg::SAMPLE_CYC,
	parameter logic [35:0] WARM_CYCLES = chi_pkg::WARM_CYC,
	parameter logic [35:0] ACCURATE_CYCLES = chi_pkg::ACCURATE_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	chi_link_if.dev link,
	input wire logic [15:0] meas_ppm,
	input wire logic [1:0] baud_sel,
	input wire logic [15:0] alarm_on_ppm,
	input wire logic [15:0] alarm_off_ppm,
	output logic [15:0] conc_ppm,
	output logic sample_stb,
	output logic warm_ok,
	output logic accurate,
	output logic alarm,
	output logic cal_ref400_active,
	output logic cal_zero_active,
	output logic cal_fault,
	output logic read_cmd_stb
);
	typedef enum logic [3:0] {
		TX_IDLE = 4'h1,
		TX_START = 4'h2,
		TX_DATA = 4'h4,
		TX_STOP = 4'h8
	} chi_tx_t;

	typedef enum logic [6:0] {
		I_IDLE = 7'h01,
		I_ADDR = 7'h02,
		I_AACK = 7'h04,
		I_WDATA = 7'h08,
		I_WACK = 7'h10,
		I_RDATA = 7'h20,
		I_RACK = 7'h40
	} chi_i2c_t;

	typedef struct packed {
		logic [35:0] smp_cnt;
		logic [35:0] up_cnt;
		logic warm;
		logic acc;
		logic [15:0] conc;
		logic alarm;
		logic smp_stb;
		chi_tx_t tx;
		logic [15:0] div;
		logic [15:0] bcnt;
		logic [2:0] bit_n;
		logic [3:0] chr;
		logic [7:0] tsh;
		logic txd;
		chi_i2c_t i2;
		logic scl_q;
		logic sda_q;
		logic [3:0] icnt;
		logic [7:0] ish;
		logic rd;
		logic [2:0] ridx;
		logic drv_low;
		logic [15:0] snap;
		logic cmd_stb;
		logic cal400;
		logic cal0;
		logic calflt;
	} chi_dev_t;

	chi_dev_t s;
	chi_dev_t next_s;
	logic [15:0] clamped;
	logic scl_rise;
	logic scl_fall;
	logic i2c_start;
	logic i2c_stop;
	logic [7:0] next_byte;

	// ------------------------------------------------------------
	// Report character generator
	// ------------------------------------------------------------
	function automatic logic [7:0] frame_char(input logic [15:0] v, input logic [3:0] idx);
		int pow;
		int dig;
		pow = 1;
		dig = 0;
		frame_char = chi_pkg::CH_SP;
		if (idx < chi_pkg::DIGITS) begin
			for (int k = 0; k < 5 - int'(idx); k++) begin
				pow = pow * 10;
			end
			dig = (int'(v) / pow) % 10;
			// Blank leading zeros but keep the units digit so zero shows as 0
			if (int'(v) >= pow || pow == 1) begin
				frame_char = chi_pkg::CH_ZERO + 8'(dig);
			end
		end else begin
			unique case (idx)
				4'h6: frame_char = chi_pkg::CH_SP;
				4'h7, 4'h8: frame_char = chi_pkg::CH_P;
				4'h9: frame_char = chi_pkg::CH_M;
				4'hA: frame_char = chi_pkg::CH_CR;
				default: frame_char = chi_pkg::CH_LF;
			endcase
		end
	endfunction

	function automatic logic [7:0] rsp_byte(input logic [2:0] idx, input logic [15:0] v);
		unique case (idx)
			3'h0: rsp_byte = chi_pkg::CFG_BYTE;
			3'h1: rsp_byte = v[15:8];
			3'h2: rsp_byte = v[7:0];
			default: rsp_byte = 8'h00;
		endcase
	endfunction

	assign clamped = (meas_ppm > chi_pkg::PPM_MAX) ? chi_pkg::PPM_MAX : meas_ppm;
	assign scl_rise = link.scl && !s.scl_q;
	assign scl_fall = !link.scl && s.scl_q;
	assign i2c_start = link.scl && s.scl_q && s.sda_q && !link.sda;
	assign i2c_stop = link.scl && s.scl_q && !s.sda_q && link.sda;
	assign next_byte = rsp_byte(s.ridx + 3'h1, s.snap);

	always_comb begin
		next_s = s;
		next_s.smp_stb = 1'b0;
		next_s.cmd_stb = 1'b0;
		next_s.scl_q = link.scl;
		next_s.sda_q = link.sda;
		next_s.cal400 = link.cal_ref400_pin && !link.cal_zero_pin;
		next_s.cal0 = !link.cal_ref400_pin && link.cal_zero_pin;
		next_s.calflt = !link.cal_ref400_pin && !link.cal_zero_pin;

		// ------------------------------------------------------------
		// Warm-up and sampling
		// ------------------------------------------------------------
		if (s.up_cnt != ACCURATE_CYCLES) begin
			next_s.up_cnt = s.up_cnt + 36'h1;
		end
		next_s.warm = s.up_cnt >= WARM_CYCLES;
		next_s.acc = s.up_cnt == ACCURATE_CYCLES;
		if (s.smp_cnt == SAMPLE_CYCLES - 36'h1) begin
			next_s.smp_cnt = '0;
			next_s.conc = clamped;
			next_s.smp_stb = 1'b1;
			if (clamped >= alarm_on_ppm) begin
				next_s.alarm = 1'b1;
			end else if (clamped <= alarm_off_ppm) begin
				next_s.alarm = 1'b0;
			end
			// A sample landing mid-frame starts no frame of its own; the frame in progress sends its remaining characters from it
			if (s.warm && s.tx == TX_IDLE) begin
				next_s.tx = TX_START;
				next_s.div = chi_pkg::baud_div(baud_sel);
				next_s.bcnt = '0;
				next_s.chr = '0;
				next_s.tsh = frame_char(clamped, 4'h0);
				next_s.txd = 1'b0;
			end
		end else begin
			next_s.smp_cnt = s.smp_cnt + 36'h1;
		end

		// ------------------------------------------------------------
		// UART transmitter, 8N1
		// ------------------------------------------------------------
		if (s.tx != TX_IDLE) begin
			if (s.bcnt == s.div - 16'h1) begin
				next_s.bcnt = '0;
				unique case (s.tx)
					TX_START: begin
						next_s.tx = TX_DATA;
						next_s.bit_n = '0;
						next_s.txd = s.tsh[0];
					end
					TX_DATA: begin
						if (s.bit_n == 3'h7) begin
							next_s.tx = TX_STOP;
							next_s.txd = 1'b1;
						end else begin
							next_s.bit_n = s.bit_n + 3'h1;
							next_s.tsh = {1'b0, s.tsh[7:1]};
							next_s.txd = s.tsh[1];
						end
					end
					TX_STOP: begin
						if (s.chr == chi_pkg::FRAME_LEN - 4'h1) begin
							next_s.tx = TX_IDLE;
						end else begin
							next_s.chr = s.chr + 4'h1;
							next_s.tsh = frame_char(s.conc, s.chr + 4'h1);
							next_s.tx = TX_START;
							next_s.txd = 1'b0;
						end
					end
					default: next_s.tx = TX_IDLE;
				endcase
			end else begin
				next_s.bcnt = s.bcnt + 16'h1;
			end
		end

		// ------------------------------------------------------------
		// I2C target; only ever pulls SDA, never drives SCL
		// ------------------------------------------------------------
		if (i2c_stop) begin
			next_s.i2 = I_IDLE;
			next_s.drv_low = 1'b0;
		end else if (i2c_start) begin
			next_s.i2 = I_ADDR;
			next_s.icnt = '0;
			next_s.drv_low = 1'b0;
		end else begin
			unique case (s.i2)
				I_IDLE: next_s.drv_low = 1'b0;
				I_ADDR, I_WDATA: begin
					if (scl_rise) begin
						next_s.ish = {s.ish[6:0], link.sda};
						next_s.icnt = s.icnt + 4'h1;
					end else if (scl_fall && s.icnt == chi_pkg::BITS_ACK) begin
						if (s.i2 == I_WDATA) begin
							next_s.drv_low = 1'b1;
							next_s.i2 = I_WACK;
							if (s.ish == chi_pkg::CMD_READ) begin
								next_s.snap = s.conc;
								next_s.cmd_stb = 1'b1;
							end
						end else if (s.ish[7:1] == chi_pkg::I2C_ADDR) begin
							next_s.drv_low = 1'b1;
							next_s.rd = s.ish[0];
							next_s.i2 = I_AACK;
						end else begin
							next_s.i2 = I_IDLE;
						end
					end
				end
				I_AACK: begin
					if (scl_fall) begin
						next_s.icnt = '0;
						if (s.rd) begin
							next_s.ridx = '0;
							next_s.ish = rsp_byte(3'h0, s.snap);
							next_s.drv_low = !chi_pkg::CFG_BYTE[7];
							next_s.i2 = I_RDATA;
						end else begin
							next_s.drv_low = 1'b0;
							next_s.i2 = I_WDATA;
						end
					end
				end
				I_WACK: begin
					if (scl_fall) begin
						next_s.drv_low = 1'b0;
						next_s.icnt = '0;
						next_s.i2 = I_WDATA;
					end
				end
				I_RDATA: begin
					if (scl_rise) begin
						next_s.icnt = s.icnt + 4'h1;
					end else if (scl_fall) begin
						if (s.icnt == chi_pkg::BITS_ACK) begin
							next_s.drv_low = 1'b0;
							next_s.i2 = I_RACK;
						end else begin
							next_s.ish = {s.ish[6:0], 1'b0};
							next_s.drv_low = !s.ish[6];
						end
					end
				end
				I_RACK: begin
					if (scl_rise && link.sda) begin
						next_s.i2 = I_IDLE;
					end else if (scl_fall && s.ridx == chi_pkg::RSP_LEN - 3'h1) begin
						// Seventh byte acked: let go of SDA so the controller can make its stop
						next_s.drv_low = 1'b0;
						next_s.i2 = I_IDLE;
					end else if (scl_fall) begin
						next_s.ridx = s.ridx + 3'h1;
						next_s.ish = next_byte;
						next_s.drv_low = !next_byte[7];
						next_s.icnt = '0;
						next_s.i2 = I_RDATA;
					end
				end
				default: next_s.i2 = I_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst || !link.rst_n_pin) begin
			s <= '0;
			s.tx <= TX_IDLE;
			s.txd <= 1'b1;
			s.i2 <= I_IDLE;
			s.scl_q <= 1'b1;
			s.sda_q <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign link.uart_txd = s.txd;
	assign link.dev_sda_o = 1'b0;
	assign link.dev_sda_oe_n = !s.drv_low;
	assign link.alarm_o = 1'b0;
	assign link.alarm_oe_n = !s.alarm;
	assign conc_ppm = s.conc;
	assign sample_stb = s.smp_stb;
	assign warm_ok = s.warm;
	assign accurate = s.acc;
	assign alarm = s.alarm;
	assign cal_ref400_active = s.cal400;
	assign cal_zero_active = s.cal0;
	assign cal_fault = s.calflt;
	assign read_cmd_stb = s.cmd_stb;
endmodule
`default_nettype wire

// ==== verilog/chi_host_end.sv ====
// Host end: I2C read sequencer, UART report receiver, calibration and reset pins
`timescale 1ns/100ps
`default_nettype none
module chi_host_end #(
	parameter logic [35:0] RD_WAIT_CYCLES = chi_pkg::RD_WAIT_CYC,
	parameter logic [39:0] CAL_HOLD_CYCLES = chi_pkg::CAL_HOLD_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	chi_link_if.host link,
	input wire logic sensor_rst,
	input wire logic read_req,
	input wire logic [1:0] baud_sel,
	input wire logic cal_ref400_req,
	input wire logic cal_zero_req,
	output logic busy,
	output logic nack,
	output logic [7:0] rsp_data,
	output logic rsp_valid,
	output logic [7:0] uart_data,
	output logic uart_valid,
	output logic uart_frame_end,
	output logic cal_busy
);
	typedef enum logic [5:0] {
		H_IDLE = 6'h01,
		H_NEXT = 6'h02,
		H_START = 6'h04,
		H_BIT = 6'h08,
		H_STOP = 6'h10,
		H_WAIT = 6'h20
	} chi_hst_t;

	typedef struct packed {
		chi_hst_t st;
		logic [15:0] qcnt;
		logic [1:0] ph;
		logic [3:0] step;
		logic [3:0] slot;
		logic [7:0] sh;
		logic rd;
		logic [2:0] nbytes;
		logic [35:0] wcnt;
		logic scl_low;
		logic sda_low;
		logic nack;
		logic [7:0] rdata;
		logic rvalid;
		logic rx_on;
		logic [15:0] rcnt;
		logic [3:0] rbit;
		logic [7:0] rsh;
		logic rxq;
		logic [7:0] udata;
		logic uvalid;
		logic uend;
		logic [39:0] ccnt;
		logic c400_low;
		logic c0_low;
	} chi_host_t;

	chi_host_t s;
	chi_host_t next_s;
	logic qtick;
	logic [15:0] div;

	assign qtick = s.qcnt == chi_pkg::I2C_QUARTER - 16'h1;
	assign div = chi_pkg::baud_div(baud_sel);

	always_comb begin
		next_s = s;
		next_s.rvalid = 1'b0;
		next_s.uvalid = 1'b0;
		next_s.uend = 1'b0;
		next_s.rxq = link.uart_txd;
		next_s.qcnt = qtick ? 16'h0 : s.qcnt + 16'h1;

		// ------------------------------------------------------------
		// I2C controller: write command, then read the response
		// ------------------------------------------------------------
		unique case (s.st)
			H_IDLE: begin
				next_s.qcnt = '0;
				if (read_req) begin
					next_s.st = H_NEXT;
					next_s.step = chi_pkg::SQ_START1;
					next_s.nack = 1'b0;
					next_s.nbytes = '0;
				end
			end
			H_NEXT: begin
				next_s.ph = '0;
				next_s.slot = '0;
				next_s.qcnt = '0;
				next_s.step = s.step + 4'h1;
				unique case (s.step)
					chi_pkg::SQ_START1, chi_pkg::SQ_START2: next_s.st = H_START;
					chi_pkg::SQ_STOP1, chi_pkg::SQ_STOP2: next_s.st = H_STOP;
					chi_pkg::SQ_WADDR: begin
						next_s.sh = chi_pkg::ADDR_WR;
						next_s.rd = 1'b0;
						next_s.st = H_BIT;
					end
					chi_pkg::SQ_CMD: begin
						next_s.sh = chi_pkg::CMD_READ;
						next_s.st = H_BIT;
					end
					chi_pkg::SQ_RADDR: begin
						next_s.sh = chi_pkg::ADDR_RD;
						next_s.rd = 1'b0;
						next_s.st = H_BIT;
					end
					chi_pkg::SQ_READ: begin
						next_s.step = s.step;
						next_s.wcnt = '0;
						next_s.st = H_WAIT;
					end
					default: next_s.st = H_IDLE;
				endcase
			end
			H_WAIT: begin
				next_s.qcnt = '0;
				next_s.wcnt = s.wcnt + 36'h1;
				if (s.wcnt == RD_WAIT_CYCLES - 36'h1) begin
					next_s.rd = 1'b1;
					next_s.st = H_BIT;
				end
			end
			H_START: begin
				if (qtick) begin
					next_s.ph = s.ph + 2'h1;
					unique case (s.ph)
						2'h0: begin
							next_s.scl_low = 1'b0;
							next_s.sda_low = 1'b0;
						end
						2'h1: next_s.sda_low = 1'b1;
						2'h2: next_s.scl_low = 1'b1;
						default: next_s.st = H_NEXT;
					endcase
				end
			end
			H_STOP: begin
				if (qtick) begin
					next_s.ph = s.ph + 2'h1;
					unique case (s.ph)
						2'h0: begin
							next_s.scl_low = 1'b1;
							next_s.sda_low = 1'b1;
						end
						2'h1: next_s.scl_low = 1'b0;
						2'h2: next_s.sda_low = 1'b0;
						default: next_s.st = (s.step == chi_pkg::SQ_DONE) ? H_IDLE : H_NEXT;
					endcase
				end
			end
			H_BIT: begin
				if (qtick) begin
					next_s.ph = s.ph + 2'h1;
					unique case (s.ph)
						2'h0: begin
							next_s.scl_low = 1'b1;
							if (s.slot == chi_pkg::BITS_ACK) begin
								next_s.sda_low = s.rd;
							end else begin
								next_s.sda_low = !s.rd && !s.sh[7];
							end
						end
						2'h1: next_s.scl_low = 1'b0;
						2'h2: begin
							if (s.slot != chi_pkg::BITS_ACK) begin
								next_s.sh = {s.sh[6:0], link.sda};
							end else if (!s.rd && link.sda) begin
								next_s.nack = 1'b1;
							end
						end
						default: begin
							next_s.scl_low = 1'b1;
							next_s.slot = s.slot + 4'h1;
							if (s.slot == chi_pkg::BITS_ACK) begin
								next_s.sda_low = 1'b0;
								next_s.st = H_NEXT;
								if (s.nack) begin
									next_s.step = chi_pkg::SQ_STOP2;
								end else if (s.rd) begin
									next_s.rdata = s.sh;
									next_s.rvalid = 1'b1;
									next_s.nbytes = s.nbytes + 3'h1;
									if (s.nbytes == chi_pkg::RSP_LEN - 3'h1) begin
										next_s.step = chi_pkg::SQ_STOP2;
									end
								end
							end
						end
					endcase
				end
			end
			default: next_s.st = H_IDLE;
		endcase

		// ------------------------------------------------------------
		// UART receiver, mid-bit sampling
		// ------------------------------------------------------------
		if (!s.rx_on) begin
			if (s.rxq && !link.uart_txd) begin
				next_s.rx_on = 1'b1;
				next_s.rcnt = {1'b0, div[15:1]};
				next_s.rbit = '0;
			end
		end else if (s.rcnt == '0) begin
			next_s.rcnt = div - 16'h1;
			next_s.rbit = s.rbit + 4'h1;
			if (s.rbit == 4'h0) begin
				next_s.rx_on = !link.uart_txd;
			end else if (s.rbit == 4'h9) begin
				next_s.rx_on = 1'b0;
				if (link.uart_txd) begin
					next_s.udata = s.rsh;
					next_s.uvalid = 1'b1;
					next_s.uend = s.rsh == chi_pkg::CH_LF;
				end
			end else begin
				next_s.rsh = {link.uart_txd, s.rsh[7:1]};
			end
		end else begin
			next_s.rcnt = s.rcnt - 16'h1;
		end

		// ------------------------------------------------------------
		// Manual calibration: one pin low, the other high, fixed hold
		// ------------------------------------------------------------
		if (s.c400_low || s.c0_low) begin
			next_s.ccnt = s.ccnt + 40'h1;
			if (s.ccnt == CAL_HOLD_CYCLES - 40'h1) begin
				next_s.c400_low = 1'b0;
				next_s.c0_low = 1'b0;
			end
		end else if (cal_ref400_req) begin
			next_s.ccnt = '0;
			next_s.c0_low = 1'b1;
		end else if (cal_zero_req) begin
			next_s.ccnt = '0;
			next_s.c400_low = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s <= '0;
			s.st <= H_IDLE;
			s.rxq <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign link.scl_o = 1'b0;
	assign link.scl_oe_n = !s.scl_low;
	assign link.host_sda_o = 1'b0;
	assign link.host_sda_oe_n = !s.sda_low;
	assign link.cal_ref400_pin = !s.c400_low;
	assign link.cal_zero_pin = !s.c0_low;
	assign link.rst_n_pin = !sensor_rst;
	assign busy = s.st != H_IDLE;
	assign nack = s.nack;
	assign rsp_data = s.rdata;
	assign rsp_valid = s.rvalid;
	assign uart_data = s.udata;
	assign uart_valid = s.uvalid;
	assign uart_frame_end = s.uend;
	assign cal_busy = s.c400_low || s.c0_low;
endmodule
`default_nettype wire

// ==== verilog/chi_link_if.sv ====
// Pin-level link between sensor end and host end
`timescale 1ns/100ps
`default_nettype none
interface chi_link_if;
	logic uart_txd;
	logic scl_o;
	logic scl_oe_n;
	logic host_sda_o;
	logic host_sda_oe_n;
	logic dev_sda_o;
	logic dev_sda_oe_n;
	logic alarm_o;
	logic alarm_oe_n;
	logic cal_ref400_pin;
	logic cal_zero_pin;
	logic rst_n_pin;
	logic scl;
	logic sda;
	logic alarm_line;
	// Pull-ups: a line is high unless some enabled driver pulls it low
	assign scl = !(!scl_oe_n && !scl_o);
	assign sda = !((!host_sda_oe_n && !host_sda_o) || (!dev_sda_oe_n && !dev_sda_o));
	assign alarm_line = !(!alarm_oe_n && !alarm_o);
	modport dev (output uart_txd, output dev_sda_o, output dev_sda_oe_n, output alarm_o,
		output alarm_oe_n, input scl, input sda, input cal_ref400_pin, input cal_zero_pin,
		input rst_n_pin);
	modport host (input uart_txd, input scl, input sda, input alarm_line, output scl_o,
		output scl_oe_n, output host_sda_o, output host_sda_oe_n, output cal_ref400_pin,
		output cal_zero_pin, output rst_n_pin);
endinterface
`default_nettype wire

// ==== verilog/chi_pkg.sv ====
// Shared constants and helpers for the gas sensor host link
// Contract
// - UART 38400 baud default, 8N1 framing
// - Baud switchable to 9600 or 19200
// - Twelve-byte report: digits, space, ppm, CR LF
// - Leading zero digits sent as spaces
// - Sensor is I2C target only
// - Sensor answers 7-bit address 0x31
// - Address byte 0x63 read, 0x62 write
// - Master writes 0x62, command 0x52, stop
// - Master restarts, sends 0x63, reads seven bytes
// - Master waits 1 ms before each byte; code waits only before the seven read bytes
// - Alarm on at >=1000, off at <=800
// - Alarm pin is open collector, sinks active
// - Alarm thresholds are configurable settings
// - Calibration pins select 400 ppm or zero
// - Both calibration pins never low together
// - Calibration ends between 10 and 18 minutes
// - Measurement updates every three seconds
// - Reported values span 0 to 2000 ppm
// - Usable after 30 s, accurate after 5 min
package chi_pkg;
	localparam longint CLK_HZ = 100_000_000;
	localparam int BAUD_DEF = 38400;
	localparam int BAUD_MID = 19200;
	localparam int BAUD_LOW = 9600;
	localparam logic [1:0] BSEL_DEF = 2'h0;
	localparam logic [1:0] BSEL_MID = 2'h1;
	localparam logic [1:0] BSEL_LOW = 2'h2;
	localparam logic [15:0] DIV_DEF = 16'(CLK_HZ / BAUD_DEF);
	localparam logic [15:0] DIV_MID = 16'(CLK_HZ / BAUD_MID);
	localparam logic [15:0] DIV_LOW = 16'(CLK_HZ / BAUD_LOW);
	localparam logic [3:0] FRAME_LEN = 4'hC;
	localparam logic [3:0] DIGITS = 4'h6;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_SP = 8'h20;
	localparam logic [7:0] CH_P = 8'h70;
	localparam logic [7:0] CH_M = 8'h6D;
	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] CH_LF = 8'h0A;
	localparam logic [6:0] I2C_ADDR = 7'h31;
	localparam logic [7:0] ADDR_WR = 8'h62;
	localparam logic [7:0] ADDR_RD = 8'h63;
	localparam logic [7:0] CMD_READ = 8'h52;
	localparam logic [7:0] CFG_BYTE = 8'h08;
	localparam logic [2:0] RSP_LEN = 3'h7;
	localparam logic [3:0] BITS_ACK = 4'h8;
	localparam logic [15:0] PPM_MAX = 16'h07D0;
	localparam logic [15:0] ALARM_ON_DEF = 16'h03E8;
	localparam logic [15:0] ALARM_OFF_DEF = 16'h0320;
	localparam longint SAMPLE_S = 3;
	localparam longint WARM_S = 30;
	localparam longint ACCURATE_S = 300;
	localparam longint RD_WAIT_US = 1000;
	localparam longint CAL_MIN_S = 600;
	localparam longint CAL_MAX_S = 1080;
	localparam logic [35:0] SAMPLE_CYC = 36'(CLK_HZ * SAMPLE_S);
	localparam logic [35:0] WARM_CYC = 36'(CLK_HZ * WARM_S);
	localparam logic [35:0] ACCURATE_CYC = 36'(CLK_HZ * ACCURATE_S);
	localparam logic [35:0] RD_WAIT_CYC = 36'(CLK_HZ * RD_WAIT_US / 1_000_000);
	localparam logic [39:0] CAL_HOLD_CYC = 40'(CLK_HZ * (CAL_MIN_S + CAL_MAX_S) / 2);
	localparam logic [15:0] I2C_QUARTER = 16'h00FA;
	localparam logic [3:0] SQ_START1 = 4'h0;
	localparam logic [3:0] SQ_WADDR = 4'h1;
	localparam logic [3:0] SQ_CMD = 4'h2;
	localparam logic [3:0] SQ_STOP1 = 4'h3;
	localparam logic [3:0] SQ_START2 = 4'h4;
	localparam logic [3:0] SQ_RADDR = 4'h5;
	localparam logic [3:0] SQ_READ = 4'h6;
	localparam logic [3:0] SQ_STOP2 = 4'h7;
	localparam logic [3:0] SQ_DONE = 4'h8;

	function automatic logic [15:0] baud_div(input logic [1:0] sel);
		unique case (sel)
			BSEL_MID: baud_div = DIV_MID;
			BSEL_LOW: baud_div = DIV_LOW;
			default: baud_div = DIV_DEF;
		endcase
	endfunction
endpackage
